/* aa_annunciator.sv */
`default_nettype none

module aa_annunciator
    import aa_pkg::*;
#(
    parameter int M          = AA_NUM_TYPES,
    parameter int N          = AA_NUM_GROUPS,
    parameter int DEB_CYCLES = AA_DEB_CYCLES,
    parameter int P          = AA_NUM_TYPES * AA_NUM_GROUPS,
    parameter int IW         = $clog2(P),
    parameter int CW         = $clog2(P + 1)
)
(
    // Clock, reset, enable
    input  wire logic          CLOCK,
    input  wire logic          RST,
    input  wire logic          CLOCK_EN,
    // Plant sensors, point index is group * M + type
    input  wire logic [P-1:0]  SENSE,
    input  wire logic [P-1:0]  CONTACT_NC,
    input  wire logic          RETAIN,
    // Flash rate square wave
    input  wire logic          RATE,
    // Operator panel
    input  wire logic          ACK,
    input  wire logic [N-1:0]  GROUP_ACK,
    // Warnings
    output logic               BUZZER,
    output logic [P-1:0]       POINT_LAMP,
    output logic [M-1:0]       TYPE_LAMP,
    output logic [N-1:0]       GROUP_LAMP,
    // Logger channels
    output logic [M-1:0]       LOG_TYPE,
    output logic [N-1:0]       LOG_GROUP,
    // Arrival queue
    output logic               QUEUE_VALID,
    output logic [IW-1:0]      QUEUE_POINT,
    input  wire logic          QUEUE_TAKE,
    // Highest priority unacknowledged point
    output logic               TOP_VALID,
    output logic [IW-1:0]      TOP_POINT
);

    localparam int W = P + N + 1;

    typedef struct packed {
        logic [W-1:0]               s1;
        logic [W-1:0]               s2;
        logic [W-1:0]               samp;
        logic [W-1:0]               clean;
        logic [W-1:0]               cprev;
        logic                       r1;
        logic                       r2;
        logic [AA_CNT_W-1:0]        cnt;
        aa_point_type [P-1:0]       st;
        logic [P-1:0]               pend;
        logic [P-1:0][IW-1:0]       q;
        logic [CW-1:0]              qn;
        logic                       buzz;
        logic [P-1:0]               plamp;
        logic [M-1:0]               tlamp;
        logic [N-1:0]               glamp;
        logic [M-1:0]               ltype;
        logic [N-1:0]               lgroup;
        logic [IW-1:0]              top;
        logic                       top_v;
    } aa_state_type;

    aa_state_type cur;
    aa_state_type nxt;

    logic [W-1:0] raw;
    logic [W-1:0] eq;
    logic [W-1:0] rise;
    logic [P-1:0] ab;
    logic [P-1:0] ack_pt;

    always_comb
    begin
        logic          tick;
        logic          pushed;
        logic [CW-1:0] n_q;
        tick   = 1'b0;
        pushed = 1'b0;
        n_q    = '0;
        nxt    = cur;

        // Polarity applied ahead of the synchroniser
        raw     = {GROUP_ACK, ACK, SENSE ^ CONTACT_NC};
        nxt.s1  = raw;
        nxt.s2  = cur.s1;
        nxt.r1  = RATE;
        nxt.r2  = cur.r1;

        // Two equal samples one window apart make a clean level
        tick    = cur.cnt == AA_CNT_W'(DEB_CYCLES - 1);
        nxt.cnt = tick ? '0 : cur.cnt + AA_CNT_W'(1);
        eq      = ~(cur.samp ^ cur.s2);
        if (tick)
        begin
            nxt.samp  = cur.s2;
            nxt.clean = (cur.clean & ~eq) | (cur.s2 & eq);
        end
        nxt.cprev = cur.clean;
        rise      = cur.clean & ~cur.cprev;
        ab        = cur.clean[P-1:0];

        for (int p = 0; p < P; p++)
        begin
            ack_pt[p] = rise[P] | rise[P + 1 + p / M];
        end

        // Arrival queue: pop head, then push lowest pending point
        n_q = cur.qn;
        if (QUEUE_TAKE && cur.qn != '0)
        begin
            for (int i = 0; i < P - 1; i++)
            begin
                nxt.q[i] = cur.q[i + 1];
            end
            nxt.q[P-1] = '0;
            n_q        = cur.qn - CW'(1);
        end
        for (int p = 0; p < P; p++)
        begin
            if (cur.pend[p] && !pushed && n_q < CW'(P))
            begin
                pushed       = 1'b1;
                nxt.q[n_q]   = IW'(p);
                nxt.pend[p]  = 1'b0;
            end
        end
        nxt.qn = pushed ? n_q + CW'(1) : n_q;

        // Per point alarm sequence
        for (int p = 0; p < P; p++)
        begin
            unique case (cur.st[p])
                AA_QUIET:
                begin
                    if (ab[p])
                    begin
                        nxt.st[p]   = AA_FLASH;
                        nxt.pend[p] = 1'b1;
                    end
                end
                AA_FLASH:
                begin
                    if (ack_pt[p])
                    begin
                        nxt.st[p] = ab[p] ? AA_STEADY : AA_QUIET;
                    end
                    else if (!ab[p] && !RETAIN)
                    begin
                        nxt.st[p] = AA_QUIET;
                    end
                    // Retention keeps flashing after input ceased
                end
                AA_STEADY:
                begin
                    if (!ab[p])
                    begin
                        nxt.st[p] = AA_QUIET;
                    end
                end
                default:
                begin
                    nxt.st[p] = AA_QUIET;
                end
            endcase
        end

        // Lamps and buzzer share the one rate signal
        nxt.buzz   = 1'b0;
        nxt.tlamp  = '0;
        nxt.glamp  = '0;
        nxt.ltype  = '0;
        nxt.lgroup = '0;
        nxt.top    = '0;
        nxt.top_v  = 1'b0;
        for (int p = 0; p < P; p++)
        begin
            nxt.plamp[p] = (cur.st[p] == AA_FLASH && cur.r2)
                         || cur.st[p] == AA_STEADY;
            if (cur.st[p] == AA_FLASH && cur.r2)
            begin
                nxt.buzz = 1'b1;
            end
            nxt.tlamp[p % M] = nxt.tlamp[p % M] | nxt.plamp[p];
            nxt.glamp[p / M] = nxt.glamp[p / M] | nxt.plamp[p];
            if (cur.st[p] != AA_QUIET)
            begin
                nxt.ltype[p % M]  = 1'b1;
                nxt.lgroup[p / M] = 1'b1;
            end
        end
        for (int p = P - 1; p >= 0; p--)
        begin
            if (cur.st[p] == AA_FLASH)
            begin
                nxt.top   = IW'(p);
                nxt.top_v = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cur <= '0;
        end
        else if (CLOCK_EN)
        begin
            cur <= nxt;
        end
    end

    assign BUZZER      = cur.buzz;
    assign POINT_LAMP  = cur.plamp;
    assign TYPE_LAMP   = cur.tlamp;
    assign GROUP_LAMP  = cur.glamp;
    assign LOG_TYPE    = cur.ltype;
    assign LOG_GROUP   = cur.lgroup;
    assign QUEUE_VALID = cur.qn != '0;
    assign QUEUE_POINT = cur.q[0];
    assign TOP_VALID   = cur.top_v;
    assign TOP_POINT   = cur.top;

    // Checks on point 0 (type 0, group 0), plus queue and reset checks over all points
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST || !CLOCK_EN);

    sequence s_steady_lit;
        cur.st[0] == AA_STEADY ##1 POINT_LAMP[0];
    endsequence

    sequence s_gone_dark;
        cur.st[0] == AA_QUIET ##1 !POINT_LAMP[0];
    endsequence

    property p_buzz;
        (cur.st[0] == AA_FLASH && cur.r2) |=> BUZZER;
    endproperty
    a_buzz: assert property (p_buzz)
        else $error("buzzer silent while point flashes");

    property p_ack;
        (cur.st[0] == AA_FLASH && ack_pt[0] && ab[0]) |=> s_steady_lit;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge did not make lamp steady");

    property p_clear;
        (cur.st[0] == AA_STEADY && !ab[0]) |=> s_gone_dark;
    endproperty
    a_clear: assert property (p_clear)
        else $error("cleared alarm lamp not extinguished");

    property p_rate;
        cur.st[0] == AA_FLASH |=> POINT_LAMP[0] == $past(cur.r2);
    endproperty
    a_rate: assert property (p_rate)
        else $error("flash lamp not following rate");

    property p_retain;
        (RETAIN && cur.st[0] == AA_FLASH && !ack_pt[0])
            |=> cur.st[0] == AA_FLASH;
    endproperty
    a_retain: assert property (p_retain)
        else $error("retained alarm dropped without acknowledge");

    property p_polarity;
        1'b1 |=> cur.s1[0] == $past(SENSE[0] ^ CONTACT_NC[0]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("contact type not applied");

    property p_type;
        POINT_LAMP[0] |-> TYPE_LAMP[0];
    endproperty
    a_type: assert property (p_type)
        else $error("type light missing");

    property p_group;
        POINT_LAMP[0] |-> GROUP_LAMP[0];
    endproperty
    a_group: assert property (p_group)
        else $error("group indicator missing");

    property p_log;
        cur.st[0] != AA_QUIET |=> LOG_TYPE[0] && LOG_GROUP[0];
    endproperty
    a_log: assert property (p_log)
        else $error("logger channel missing");

    property p_prio;
        cur.st[0] == AA_FLASH |=> TOP_VALID && TOP_POINT == '0;
    endproperty
    a_prio: assert property (p_prio)
        else $error("point 0 not given top priority");

    property p_queue;
        (cur.pend != '0 && cur.qn == '0) |=> QUEUE_VALID;
    endproperty
    a_queue: assert property (p_queue)
        else $error("pending alarm not queued");

    property p_reset;
        disable iff (1'b0)
        RST |=> !BUZZER && POINT_LAMP == '0 && !QUEUE_VALID;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset left warnings on");

endmodule : aa_annunciator

`default_nettype wire

/* aa_pkg.sv */
// What this block does
// - Abnormal input flashes lamp, pulses buzzer
// - Acknowledge silences buzzer, lamp goes steady
// - Cleared acknowledged alarm turns lamp off
// - One square wave paces lamp and buzzer
// - Retention latch holds alarm until acknowledge
// - Each input normally open or normally closed
// - Same fault type ORed onto type light
// - Group fault types ORed onto group indicator
// - Logger sees only type and group channels
// - Optional queue presents alarms in arrival order
// - Fixed priority, lower point index wins
`default_nettype none

package aa_pkg;

    // Plant arrangement: m fault types by n groups
    localparam int AA_NUM_TYPES  = 4;
    localparam int AA_NUM_GROUPS = 4;

    // Debounce window
    localparam int AA_CLK_PERIOD_NS = 100;
    localparam int AA_DEB_TIME_NS   = 5000000;
    localparam int AA_DEB_CYCLES    = AA_DEB_TIME_NS / AA_CLK_PERIOD_NS;
    localparam int AA_CNT_W         = 16;

    // Per point alarm state
    typedef enum logic [1:0] {
        AA_QUIET  = 2'b00,
        AA_FLASH  = 2'b01,
        AA_STEADY = 2'b10
    } aa_point_type;

endpackage : aa_pkg

`default_nettype wire

/* aa_plant.sv */
`default_nettype none

module aa_plant
    import aa_pkg::*;
#(
    parameter int P    = 16,
    parameter int HALF = 8
)
(
    // Clock
    input  wire logic         clock,
    // Plant condition per point
    input  wire logic [P-1:0] abnormal,
    input  wire logic [P-1:0] contact_nc,
    // Contact levels and flash wave
    output logic [P-1:0]      sense,
    output logic              rate
);
    timeunit 1ns;
    timeprecision 1ns;

    int   cnt  = 0;
    logic wave = 1'b0;

    // Closed contact opens on fault, open contact closes
    assign sense = abnormal ^ contact_nc;

    // Free running square wave
    assign rate = wave;
    always @(negedge clock)
    begin
        cnt = (cnt + 1) % HALF;
        if (cnt == 0)
            wave <= ~wave;
    end
endmodule : aa_plant

`default_nettype wire

/* testbench.sv */
`default_nettype none

module testbench
    import aa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int DEB = 4;
    localparam int M   = AA_NUM_TYPES;
    localparam int N   = AA_NUM_GROUPS;
    localparam int P   = M * N;
    localparam int IW  = $clog2(P);
    localparam int LAT = 2 * DEB + 16;

    logic          clock = 0;
    logic          rst = 1;
    logic [P-1:0]  abnormal = '0;
    logic [P-1:0]  nc = '0;
    logic          retain = 0;
    logic          ack = 0;
    logic [N-1:0]  gack = '0;
    logic          take = 0;
    logic          en = 1;
    logic [P-1:0]  sense;
    logic          rate;
    logic          buzzer;
    logic [P-1:0]  point_lamp;
    logic [M-1:0]  type_lamp;
    logic [N-1:0]  group_lamp;
    logic [M-1:0]  log_type;
    logic [N-1:0]  log_group;
    logic          qvalid;
    logic [IW-1:0] qpoint;
    logic          tvalid;
    logic [IW-1:0] tpoint;
    int            n_fail = 0;
    int            n_tests = 0;
    int            p;
    int            a;
    logic [31:0]   snap;
    logic [IW-1:0] exp_q[$];

    initial forever #50 clock = ~clock;

    aa_plant #(.P(P), .HALF(8)) u_aa_plant (
        .clock(clock), .abnormal(abnormal), .contact_nc(nc),
        .sense(sense), .rate(rate));

    aa_annunciator #(.DEB_CYCLES(DEB)) u_aa_annunciator (
        .CLOCK(clock), .RST(rst), .CLOCK_EN(en), .SENSE(sense),
        .CONTACT_NC(nc), .RETAIN(retain), .RATE(rate), .ACK(ack),
        .GROUP_ACK(gack), .BUZZER(buzzer), .POINT_LAMP(point_lamp),
        .TYPE_LAMP(type_lamp), .GROUP_LAMP(group_lamp),
        .LOG_TYPE(log_type), .LOG_GROUP(log_group),
        .QUEUE_VALID(qvalid), .QUEUE_POINT(qpoint), .QUEUE_TAKE(take),
        .TOP_VALID(tvalid), .TOP_POINT(tpoint));

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task report_and_stop;
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task wait_cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_cyc

    task press(input bit grp, input int g);
        if (grp)
            gack[g] = 1'b1;
        else
            ack = 1'b1;
        wait_cyc(3 * DEB);
        ack = 1'b0;
        gack = '0;
        wait_cyc(LAT);
    endtask : press

    task flash_check(input int q);
        int   toggles;
        logic last;
        toggles = 0;
        last = point_lamp[q];
        repeat (40)
        begin
            @(negedge clock);
            check(buzzer, point_lamp[q]);
            check(type_lamp[q % M], point_lamp[q]);
            check(group_lamp[q / M], point_lamp[q]);
            if (point_lamp[q] !== last)
                toggles++;
            last = point_lamp[q];
        end
        check(toggles >= 2, 1'b1);
        check({log_type, log_group},
              (16'h1 << (N + q % M)) | (16'h1 << (q / M)));
        check({tvalid, tpoint}, {1'b1, IW'(q)});
    endtask : flash_check

    // Queue head compared with arrival order on each pop
    always @(posedge clock)
        if (qvalid === 1'b1 && take === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check(qpoint, exp_q.pop_front());
        end

    initial
    begin
        void'($urandom(32'h58c8));
        nc = P'($urandom());
        wait_cyc(8);
        check({buzzer, point_lamp, tvalid, qvalid}, '0);
        rst = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            p = $urandom_range(P - 1);
            abnormal[p] = 1'b1;
            exp_q.push_back(IW'(p));
            wait_cyc(LAT);
            flash_check(p);
            press(i == 2, p / M);
            check({point_lamp[p], buzzer}, 2'b10);
            abnormal[p] = 1'b0;
            wait_cyc(LAT);
            check({point_lamp, log_type}, '0);
        end
        // Brief fault held by the retention latch
        retain = 1'b1;
        p = $urandom_range(P - 1);
        abnormal[p] = 1'b1;
        exp_q.push_back(IW'(p));
        wait_cyc(LAT);
        abnormal[p] = 1'b0;
        wait_cyc(LAT);
        check({log_type[p % M], tpoint}, {1'b1, IW'(p)});
        press(0, 0);
        check(point_lamp, '0);
        retain = 1'b0;
        // Two faults at once, lower index first
        a = $urandom_range(P / 2 - 1);
        abnormal[a] = 1'b1;
        abnormal[a + P / 2] = 1'b1;
        exp_q.push_back(IW'(a));
        exp_q.push_back(IW'(a + P / 2));
        wait_cyc(LAT);
        check({tvalid, tpoint}, {1'b1, IW'(a)});
        abnormal[a] = 1'b0;
        wait_cyc(LAT);
        check({tvalid, tpoint}, {1'b1, IW'(a + P / 2)});
        abnormal = '0;
        wait_cyc(LAT);
        check(tvalid, 1'b0);
        repeat (2 * P)
        begin
            @(negedge clock);
            take = qvalid;
        end
        take = 1'b0;
        check({qvalid, 16'(exp_q.size())}, '0);
        // Reset in mid alarm
        abnormal[3] = 1'b1;
        wait_cyc(LAT);
        // Low enable freezes a flashing lamp
        snap = {buzzer, point_lamp, tvalid, tpoint};
        en = 1'b0;
        repeat (20)
        begin
            @(negedge clock);
            check({buzzer, point_lamp, tvalid, tpoint}, snap);
        end
        en = 1'b1;
        rst = 1'b1;
        wait_cyc(2);
        check({buzzer, point_lamp, type_lamp, qvalid}, '0);
        rst = 1'b0;
        wait_cyc(LAT);
        check({tvalid, tpoint}, {1'b1, IW'(3)});
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
